// ===== pigp_defines.vh
// register indices, field positions, reset values and timing counts for the port block
`ifndef PIGP_DEFINES_VH
`define PIGP_DEFINES_VH

// register indices; byte address is four times the index
`define PIGP_IDX_TWO_PIN_EDGE_POLARITY 6'h2d
`define PIGP_IDX_TWO_PIN_IRQ_ENABLE 6'h2e
`define PIGP_IDX_TWO_PIN_EDGE_FLAG 6'h2f
`define PIGP_IDX_ANALOG_PORT_OUT_DATA 6'h30
`define PIGP_IDX_ANALOG_PORT_PIN_IN 6'h31
`define PIGP_IDX_ANALOG_PORT_DIR 6'h32
`define PIGP_IDX_ANALOG_PORT_DRIVE_SEL 6'h33
`define PIGP_IDX_ANALOG_PORT_PULL_EN 6'h34
`define PIGP_IDX_ANALOG_PORT_PULL_SEL 6'h35

// two-pin port field positions inside an 8-bit register
`define PIGP_TWO_PIN_HI 7
`define PIGP_TWO_PIN_LO 6

// reset values
`define PIGP_RST_TWO_PIN 2'h0
`define PIGP_RST_BYTE 8'h00

// edge filter: consecutive samples of each level
`define PIGP_FILTER_SAMPLES 3'h4

// bus responses
`define PIGP_RESP_OKAY 2'h0
`define PIGP_RESP_SLVERR 2'h2

`endif

// ===== pigp_port.v
// port block: two-pin edge interrupts and eight-pin analog-shared general purpose port
// Summary of operation
// - per-pin interrupt enable, bits 7 and 6
// - active edge on pin sets its flag
// - writing one clears flag, zero leaves it
// - interrupt when flag and enable both set
// - data read: register if output, pin if input
// - input register reads pins, ignores writes
// - direction bit zero input, one output
// - reads may lag direction change three cycles
// - reduced drive bit only acts on outputs
// - pull enable acts on inputs, off after reset
// - converter channel enabled forces pull off
// - pull select picks up or down device
// - drive and pull select reset to zero
// - polarity bit picks falling or rising edge
// - four passive then four active samples
// - every register cleared on reset
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pigp_defines.vh"

module pigp_port #(
    parameter ADDR_W = 8
) (
    input wire clock_i,
    input wire rst_i,
    // axi4-lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // two-pin port inputs, bit 1 is pin 7, bit 0 is pin 6
    input wire [1:0] two_pin_i,
    // analog-shared port pins
    input wire [7:0] analog_port_pin_i,
    output reg [7:0] analog_port_pin_o,
    output reg [7:0] analog_port_pin_oe_o,
    output reg [7:0] analog_port_reduced_drive_o,
    output reg [7:0] analog_port_pull_up_o,
    output reg [7:0] analog_port_pull_down_o,
    // converter channel enables, one per analog-shared pin
    input wire [7:0] analog_converter_chan_en_i,
    output reg irq_o
);

    // register storage
    reg [1:0] two_pin_edge_polarity_reg;
    reg [1:0] two_pin_irq_enable_reg;
    reg [1:0] two_pin_edge_flag_reg;
    reg [1:0] two_pin_edge_flag_next;
    reg [7:0] analog_port_out_data_reg;
    reg [7:0] analog_port_dir_reg;
    reg [7:0] analog_port_drive_sel_reg;
    reg [7:0] analog_port_pull_en_reg;
    reg [7:0] analog_port_pull_sel_reg;
    reg [7:0] pull_up_req_reg;
    reg [7:0] pull_down_req_reg;

    // pin sampling
    reg [7:0] analog_sync1_reg;
    reg [7:0] analog_sync2_reg;
    reg [1:0] two_pin_sync1_reg;
    reg [1:0] two_pin_sync2_reg;

    // edge filter state per two-pin line
    reg [2:0] passive_cnt_reg [0:1];
    reg [2:0] active_cnt_reg [0:1];
    reg [1:0] armed_reg;
    reg [1:0] edge_seen;

    // bus write and read side
    reg aw_full_reg;
    reg [5:0] aw_idx_reg;
    reg w_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire do_write;
    reg wr_hit;
    reg [1:0] wr_clear;
    reg [1:0] polarity_chg;
    reg [31:0] rd_value;
    reg rd_hit;
    integer k;
    integer j;

    // last count before a line arms or an edge is accepted
    localparam [2:0] FILTER_LAST = `PIGP_FILTER_SAMPLES - 3'h1;

    // register index from a byte address
    function [5:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[7:2];
        end
    endfunction

    // true when the index names a register of the block
    function idx_mapped;
        input [5:0] idx;
        begin
            idx_mapped = (idx >= `PIGP_IDX_TWO_PIN_EDGE_POLARITY) && (idx <= `PIGP_IDX_ANALOG_PORT_PULL_SEL);
        end
    endfunction

    // read-back mix of data register and sampled pins
    function [7:0] data_view;
        input [7:0] stored;
        input [7:0] pins;
        input [7:0] dir;
        begin
            data_view = (stored & dir) | (pins & ~dir);
        end
    endfunction

    // two-pin field of a bus word
    function [1:0] two_pin_bits;
        input [31:0] word;
        begin
            two_pin_bits = word[`PIGP_TWO_PIN_HI:`PIGP_TWO_PIN_LO];
        end
    endfunction

    // filter sample at the level the polarity bit calls active
    function sample_active;
        input level;
        input polarity;
        begin
            sample_active = (level == polarity);
        end
    endfunction

    // pull may act only on an input pin with its enable set
    function [7:0] pull_allowed;
        input [7:0] en;
        input [7:0] dir;
        begin
            pull_allowed = en & ~dir;
        end
    endfunction

    assign s_axi_awready_o = ~aw_full_reg & ~s_axi_bvalid_o;
    assign s_axi_wready_o = ~w_full_reg & ~s_axi_bvalid_o;
    assign s_axi_arready_o = ~s_axi_rvalid_o;
    assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid_o;

    // capture write address and data in either order
    always @(posedge clock_i) begin
        if (rst_i) begin
            aw_full_reg <= 1'b0;
            aw_idx_reg <= 6'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `PIGP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_full_reg <= 1'b1;
                aw_idx_reg <= reg_index(s_axi_awaddr_i);
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= idx_mapped(aw_idx_reg) ? `PIGP_RESP_OKAY : `PIGP_RESP_SLVERR;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // write only takes effect when byte lane 0 is enabled
    always @* begin
        wr_hit = do_write & w_strb_reg[0];
        wr_clear = 2'h0;
        polarity_chg = 2'h0;
        if (wr_hit && (aw_idx_reg == `PIGP_IDX_TWO_PIN_EDGE_FLAG)) begin
            wr_clear = two_pin_bits(w_data_reg);
        end
        // a polarity flip swaps active and passive levels of the filter
        if (wr_hit && (aw_idx_reg == `PIGP_IDX_TWO_PIN_EDGE_POLARITY)) begin
            polarity_chg = two_pin_bits(w_data_reg) ^ two_pin_edge_polarity_reg;
        end
    end

    // software registers
    always @(posedge clock_i) begin
        if (rst_i) begin
            two_pin_edge_polarity_reg <= `PIGP_RST_TWO_PIN;
            two_pin_irq_enable_reg <= `PIGP_RST_TWO_PIN;
            analog_port_out_data_reg <= `PIGP_RST_BYTE;
            analog_port_dir_reg <= `PIGP_RST_BYTE;
            analog_port_drive_sel_reg <= `PIGP_RST_BYTE;
            analog_port_pull_en_reg <= `PIGP_RST_BYTE;
            analog_port_pull_sel_reg <= `PIGP_RST_BYTE;
        end else if (wr_hit) begin
            if (aw_idx_reg == `PIGP_IDX_TWO_PIN_EDGE_POLARITY) begin
                two_pin_edge_polarity_reg <= two_pin_bits(w_data_reg);
            end else if (aw_idx_reg == `PIGP_IDX_TWO_PIN_IRQ_ENABLE) begin
                two_pin_irq_enable_reg <= two_pin_bits(w_data_reg);
            end else if (aw_idx_reg == `PIGP_IDX_ANALOG_PORT_OUT_DATA) begin
                analog_port_out_data_reg <= w_data_reg[7:0];
            end else if (aw_idx_reg == `PIGP_IDX_ANALOG_PORT_DIR) begin
                analog_port_dir_reg <= w_data_reg[7:0];
            end else if (aw_idx_reg == `PIGP_IDX_ANALOG_PORT_DRIVE_SEL) begin
                analog_port_drive_sel_reg <= w_data_reg[7:0];
            end else if (aw_idx_reg == `PIGP_IDX_ANALOG_PORT_PULL_EN) begin
                analog_port_pull_en_reg <= w_data_reg[7:0];
            end else if (aw_idx_reg == `PIGP_IDX_ANALOG_PORT_PULL_SEL) begin
                analog_port_pull_sel_reg <= w_data_reg[7:0];
            end
            // pin input register: writes fall through with no effect
        end
    end

    // two-stage pin sampling, source of the read lag
    always @(posedge clock_i) begin
        if (rst_i) begin
            analog_sync1_reg <= `PIGP_RST_BYTE;
            analog_sync2_reg <= `PIGP_RST_BYTE;
            two_pin_sync1_reg <= `PIGP_RST_TWO_PIN;
            two_pin_sync2_reg <= `PIGP_RST_TWO_PIN;
        end else begin
            analog_sync1_reg <= analog_port_pin_i;
            analog_sync2_reg <= analog_sync1_reg;
            two_pin_sync1_reg <= two_pin_i;
            two_pin_sync2_reg <= two_pin_sync1_reg;
        end
    end

    // edge filter: level equal to polarity bit is active
    always @* begin
        for (j = 0; j < 2; j = j + 1) begin
            edge_seen[j] = armed_reg[j] & sample_active(two_pin_sync2_reg[j], two_pin_edge_polarity_reg[j])
                & (active_cnt_reg[j] == FILTER_LAST);
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            for (k = 0; k < 2; k = k + 1) begin
                passive_cnt_reg[k] <= 3'h0;
                active_cnt_reg[k] <= 3'h0;
            end
            armed_reg <= 2'h0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (polarity_chg[k]) begin
                    // old samples no longer count, no false edge
                    passive_cnt_reg[k] <= 3'h0;
                    active_cnt_reg[k] <= 3'h0;
                    armed_reg[k] <= 1'b0;
                end else if (sample_active(two_pin_sync2_reg[k], two_pin_edge_polarity_reg[k])) begin
                    passive_cnt_reg[k] <= 3'h0;
                    if (edge_seen[k]) begin
                        armed_reg[k] <= 1'b0;
                        active_cnt_reg[k] <= 3'h0;
                    end else if (armed_reg[k]) begin
                        active_cnt_reg[k] <= active_cnt_reg[k] + 3'h1;
                    end
                end else begin
                    active_cnt_reg[k] <= 3'h0;
                    if (passive_cnt_reg[k] == FILTER_LAST) begin
                        armed_reg[k] <= 1'b1;
                    end else begin
                        passive_cnt_reg[k] <= passive_cnt_reg[k] + 3'h1;
                    end
                end
            end
        end
    end

    // sticky flags, a new edge wins over a clear in the same cycle
    always @* begin
        two_pin_edge_flag_next = (two_pin_edge_flag_reg & ~wr_clear) | edge_seen;
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            two_pin_edge_flag_reg <= `PIGP_RST_TWO_PIN;
            irq_o <= 1'b0;
        end else begin
            two_pin_edge_flag_reg <= two_pin_edge_flag_next;
            irq_o <= |(two_pin_edge_flag_next & two_pin_irq_enable_reg);
        end
    end

    // pin drivers
    always @(posedge clock_i) begin
        if (rst_i) begin
            analog_port_pin_o <= `PIGP_RST_BYTE;
            analog_port_pin_oe_o <= `PIGP_RST_BYTE;
            analog_port_reduced_drive_o <= `PIGP_RST_BYTE;
            pull_up_req_reg <= `PIGP_RST_BYTE;
            pull_down_req_reg <= `PIGP_RST_BYTE;
        end else begin
            analog_port_pin_o <= analog_port_out_data_reg;
            analog_port_pin_oe_o <= analog_port_dir_reg;
            analog_port_reduced_drive_o <= analog_port_drive_sel_reg & analog_port_dir_reg;
            pull_up_req_reg <= pull_allowed(analog_port_pull_en_reg, analog_port_dir_reg)
                & ~analog_port_pull_sel_reg;
            pull_down_req_reg <= pull_allowed(analog_port_pull_en_reg, analog_port_dir_reg)
                & analog_port_pull_sel_reg;
        end
    end

    // converter channel blocks pulls at once, not a cycle late
    always @* begin
        analog_port_pull_up_o = pull_up_req_reg & ~analog_converter_chan_en_i;
        analog_port_pull_down_o = pull_down_req_reg & ~analog_converter_chan_en_i;
    end

    // read decode
    always @* begin
        rd_value = 32'h00000000;
        rd_hit = 1'b1;
        if (reg_index(s_axi_araddr_i) == `PIGP_IDX_TWO_PIN_EDGE_POLARITY) begin
            rd_value[`PIGP_TWO_PIN_HI:`PIGP_TWO_PIN_LO] = two_pin_edge_polarity_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_TWO_PIN_IRQ_ENABLE) begin
            rd_value[`PIGP_TWO_PIN_HI:`PIGP_TWO_PIN_LO] = two_pin_irq_enable_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_TWO_PIN_EDGE_FLAG) begin
            rd_value[`PIGP_TWO_PIN_HI:`PIGP_TWO_PIN_LO] = two_pin_edge_flag_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_OUT_DATA) begin
            rd_value[7:0] = data_view(analog_port_out_data_reg, analog_sync2_reg, analog_port_dir_reg);
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_PIN_IN) begin
            rd_value[7:0] = analog_sync2_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_DIR) begin
            rd_value[7:0] = analog_port_dir_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_DRIVE_SEL) begin
            rd_value[7:0] = analog_port_drive_sel_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_PULL_EN) begin
            rd_value[7:0] = analog_port_pull_en_reg;
        end else if (reg_index(s_axi_araddr_i) == `PIGP_IDX_ANALOG_PORT_PULL_SEL) begin
            rd_value[7:0] = analog_port_pull_sel_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `PIGP_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_value;
            s_axi_rresp_o <= rd_hit ? `PIGP_RESP_OKAY : `PIGP_RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== pigp_port_checker.sv
// checker for the port block: pin gating, reset and bus handshakes
`timescale 1ns/1ps
`default_nettype none
module pigp_port_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic s_axi_awready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [7:0] analog_port_pin_oe_o,
    input wire logic [7:0] analog_port_reduced_drive_o,
    input wire logic [7:0] analog_port_pull_up_o,
    input wire logic [7:0] analog_port_pull_down_o,
    input wire logic [7:0] analog_converter_chan_en_i,
    input wire logic irq_o
);
    wire logic [7:0] pulls = analog_port_pull_up_o | analog_port_pull_down_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_drive_out; (analog_port_reduced_drive_o & ~analog_port_pin_oe_o) == 8'h00; endproperty
    a_drive_out: assert property (p_drive_out) else $error("reduced drive on an input pin");
    property p_pull_in; (pulls & analog_port_pin_oe_o) == 8'h00; endproperty
    a_pull_in: assert property (p_pull_in) else $error("pull active on an output pin");
    property p_pull_conv; (pulls & analog_converter_chan_en_i) == 8'h00; endproperty
    a_pull_conv: assert property (p_pull_conv) else $error("pull active with converter channel on");
    property p_pull_excl; (analog_port_pull_up_o & analog_port_pull_down_o) == 8'h00; endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
    property p_reset;
        disable iff (1'b0) rst_i |=> !irq_o && analog_port_pin_oe_o == 8'h00 && pulls == 8'h00 && !s_axi_bvalid_o;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_r_answer; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_done; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer not retired");
    property p_b_done; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer not retired");
    property p_aw_refuse; s_axi_bvalid_o |-> !s_axi_awready_o; endproperty
    a_aw_refuse: assert property (p_aw_refuse) else $error("write address taken with answer pending");
    c_irq: cover property ($rose(irq_o));
    c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
    c_pull_down: cover property (analog_port_pull_down_o != 8'h00);
endmodule
`default_nettype wire

// ===== pigp_pin_model.sv
// external pin model for the analog-shared port
`timescale 1ns/1ps
`default_nettype none
module pigp_pin_model (
    input wire logic clock_i,
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    input wire logic [7:0] pd_i,
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    output logic [7:0] level_o
);
    logic [7:0] last_reg = 8'h00;
    // floating pins with no pull toggle every cycle
    assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
        | (~oe_i & ~ext_en_i & (pu_i | (~pd_i & ~last_reg)));
    always @(posedge clock_i) begin
        last_reg <= level_o;
    end
endmodule
`default_nettype wire

// ===== tb.sv
// testbench for the port block
`timescale 1ns/1ps
`default_nettype none
`include "pigp_defines.vh"
bind pigp_port pigp_port_checker chk_u (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .analog_port_pin_oe_o(analog_port_pin_oe_o),
    .analog_port_reduced_drive_o(analog_port_reduced_drive_o), .analog_port_pull_up_o(analog_port_pull_up_o),
    .analog_port_pull_down_o(analog_port_pull_down_o), .analog_converter_chan_en_i(analog_converter_chan_en_i),
    .irq_o(irq_o));
module tb;
    logic clock_i, rst_i, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr, chan_en, ext_val, ext_en, pin_o, oe, rd, pu, pd, pin_i;
    logic [31:0] wdata, rdata, rd_d;
    logic [1:0] two_pin, bresp, rresp, rd_r;
    logic [3:0] strb;
    int failures, samples_checked;
    pigp_port dut_u (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .two_pin_i(two_pin), .analog_port_pin_i(pin_i), .analog_port_pin_o(pin_o),
        .analog_port_pin_oe_o(oe), .analog_port_reduced_drive_o(rd), .analog_port_pull_up_o(pu),
        .analog_port_pull_down_o(pd), .analog_converter_chan_en_i(chan_en), .irq_o(irq));
    pigp_pin_model pins_u (.clock_i(clock_i), .drv_i(pin_o), .oe_i(oe), .pu_i(pu), .pd_i(pd),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    task final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task stall;
        failures++;
        $display("Error at %0t: bus wait ran out", $time);
        final_report();
    endtask
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: response %h expected %h", $time, got, exp);
        end
    endtask
    task axi_write(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic a, w, done;
        @(posedge clock_i);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(negedge clock_i);
            a = awvalid & awready;
            w = wvalid & wready;
            if (bvalid) begin
                done = 1'b1;
                chk_resp(bresp, er);
            end
            @(posedge clock_i);
            if (a)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!done)
            stall();
    endtask
    task axi_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic t, done;
        @(posedge clock_i);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 50 && !done; n++) begin
            @(negedge clock_i);
            t = arvalid & arready;
            if (rvalid) begin
                done = 1'b1;
                d = rdata;
                r = rresp;
            end
            @(posedge clock_i);
            if (t)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!done)
            stall();
    endtask
    task wr(input logic [5:0] idx, input logic [7:0] d);
        axi_write(idx, d, `PIGP_RESP_OKAY);
    endtask
    task rd_chk(input logic [5:0] idx, input logic [7:0] e);
        axi_read(idx, rd_d, rd_r);
        chk_val(rd_d, {24'h0, e});
        chk_resp(rd_r, `PIGP_RESP_OKAY);
    endtask
    task pins2(input logic [1:0] v, input int k);
        @(posedge clock_i);
        two_pin <= v;
        repeat (k) @(posedge clock_i);
    endtask
    task look;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    initial begin
        rst_i = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, chan_en} = 24'h0;
        wdata = 32'h0;
        strb = 4'hf;
        two_pin = 2'h3;
        ext_val = 8'h03;
        ext_en = 8'h0f;
        failures = 0;
        samples_checked = 0;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk(`PIGP_IDX_ANALOG_PORT_DRIVE_SEL, 8'h00);
        rd_chk(`PIGP_IDX_ANALOG_PORT_PULL_SEL, 8'h00);
        rd_chk(`PIGP_IDX_ANALOG_PORT_PULL_EN, 8'h00);
        rd_chk(`PIGP_IDX_TWO_PIN_IRQ_ENABLE, 8'h00);
        axi_read(6'h00, rd_d, rd_r);
        chk_resp(rd_r, `PIGP_RESP_SLVERR);
        axi_write(6'h3f, 8'hff, `PIGP_RESP_SLVERR);
        $display("test reset and map done");
        wr(`PIGP_IDX_ANALOG_PORT_OUT_DATA, 8'ha5);
        wr(`PIGP_IDX_ANALOG_PORT_DIR, 8'hf0);
        look;
        chk_val(oe, 8'hf0);
        rd_chk(`PIGP_IDX_ANALOG_PORT_OUT_DATA, 8'ha3);
        wr(`PIGP_IDX_ANALOG_PORT_PIN_IN, 8'hff);
        rd_chk(`PIGP_IDX_ANALOG_PORT_PIN_IN, 8'ha3);
        wr(`PIGP_IDX_ANALOG_PORT_DIR, 8'hff);
        repeat (2) @(posedge clock_i);
        rd_chk(`PIGP_IDX_ANALOG_PORT_PIN_IN, 8'ha5);
        wr(`PIGP_IDX_ANALOG_PORT_DRIVE_SEL, 8'h3c);
        wr(`PIGP_IDX_ANALOG_PORT_DIR, 8'h0f);
        @(posedge clock_i);
        chan_en <= 8'h10;
        wr(`PIGP_IDX_ANALOG_PORT_PULL_SEL, 8'hc3);
        wr(`PIGP_IDX_ANALOG_PORT_PULL_EN, 8'hff);
        look;
        chk_val(rd, 8'h0c);
        chk_val(pu, 8'h20);
        chk_val(pd, 8'hc0);
        axi_read(`PIGP_IDX_ANALOG_PORT_PIN_IN, rd_d, rd_r);
        chk_val(rd_d & 32'hef, 32'h25);
        strb <= 4'h0;
        wr(`PIGP_IDX_ANALOG_PORT_DIR, 8'h55);
        strb <= 4'hf;
        rd_chk(`PIGP_IDX_ANALOG_PORT_DIR, 8'h0f);
        $display("test port pins done");
        wr(`PIGP_IDX_TWO_PIN_IRQ_ENABLE, 8'h80);
        pins2(2'h2, 12);
        look;
        chk_val(irq, 1'b0);
        rd_chk(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h40);
        wr(`PIGP_IDX_TWO_PIN_IRQ_ENABLE, 8'hc0);
        look;
        chk_val(irq, 1'b1);
        pins2(2'h3, 12);
        pins2(2'h1, 2);
        pins2(2'h3, 12);
        rd_chk(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h40);
        wr(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h80);
        rd_chk(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h40);
        wr(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h40);
        look;
        chk_val(irq, 1'b0);
        pins2(2'h0, 12);
        wr(`PIGP_IDX_TWO_PIN_EDGE_POLARITY, 8'hc0);
        wr(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'hc0);
        rd_chk(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'h00);
        pins2(2'h3, 12);
        rd_chk(`PIGP_IDX_TWO_PIN_EDGE_FLAG, 8'hc0);
        $display("test edge interrupts done");
        final_report();
    end
endmodule
`default_nettype wire
